// >>> fdsep_pkg.sv
// Shared constants and types of the floppy read data separator
`default_nettype none
package fdsep_pkg;
  // System clock period
  localparam int CLK_PERIOD_NS = 10;
  // Shortest write clock period, one microsecond
  localparam int CELL_BASE_NS  = 1000;
  // Width of the bit cell counters
  localparam int CELL_W        = 9;
  // Window width at the shortest period, in clock cycles
  localparam logic [CELL_W-1:0] CELL_BASE_CYC = CELL_W'(CELL_BASE_NS / CLK_PERIOD_NS);
  // Least high time of the regenerated read pulse
  localparam int RD_PULSE_NS   = 150;
  localparam int RD_W          = 5;
  localparam logic [RD_W-1:0] RD_PULSE_CYC =
    RD_W'((RD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Reference edge counter, one count per 16 MHz period
  localparam int REF_DIV_W     = 6;
  // Counter bit that gives 8 MHz, 2 MHz and a 1 us period
  localparam int PRI_BIT       = 0;
  localparam int SEC_BIT       = 2;
  localparam int WCLK_BIT      = 3;
  // Reset values of the clock outputs
  localparam logic CLK_RST     = 1'b0;
  // Width of the one-shot duration count
  localparam int ONESHOT_W     = 16;
  // Loop filter mode, one-hot
  typedef enum logic [1:0] {
    LOOP_ACQUIRE = 2'b01,
    LOOP_TRACK   = 2'b10
  } loop_mode_t;
endpackage
`default_nettype wire

// >>> mode_if.sv
// Drive size and density selection carried between modules
`default_nettype none
interface mode_if;
  logic small_drive;    // High for the smaller drive format
  logic double_density; // High for MFM, low for FM
  modport drive (output small_drive, output double_density);
  modport use_sel (input small_drive, input double_density);
endinterface
`default_nettype wire

// >>> ref_clock_divider.sv
// Controller and write clocks divided from the 16 MHz reference
`default_nettype none
module ref_clock_divider (
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic reference_osc_in_i,
  mode_if.use_sel   sel,
  output logic      primary_ctrl_clock_o,
  output logic      secondary_ctrl_clock_o,
  output logic      write_clock_o
);
  logic                                ref_q;   // Previous reference level
  logic                                tick;    // Reference rising edge
  logic [fdsep_pkg::REF_DIV_W-1:0]     cnt_q;   // Reference edge count
  logic [fdsep_pkg::REF_DIV_W-1:0]     cnt_d;
  int                                  shift;   // Extra divide by size
  int                                  wshift;  // Extra divide by size and density

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= reference_osc_in_i;
    end
  end
  assign tick = reference_osc_in_i & ~ref_q;

  assign cnt_d  = tick ? cnt_q + 1'b1 : cnt_q;
  assign shift  = sel.small_drive ? 1 : 0;
  assign wshift = shift + (sel.double_density ? 0 : 1);

  // Edge counter
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // clock taps chosen by size and density
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      primary_ctrl_clock_o   <= fdsep_pkg::CLK_RST;
      secondary_ctrl_clock_o <= fdsep_pkg::CLK_RST;
      write_clock_o          <= fdsep_pkg::CLK_RST;
    end else begin
      primary_ctrl_clock_o   <= cnt_d[fdsep_pkg::PRI_BIT + shift];
      secondary_ctrl_clock_o <= cnt_d[fdsep_pkg::SEC_BIT + shift];
      write_clock_o          <= cnt_d[fdsep_pkg::WCLK_BIT + wshift];
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  pri_on_tick_a: assert property (
    (tick && !sel.small_drive && $stable(sel.small_drive))
      |=> $changed(primary_ctrl_clock_o))
    else $error("primary clock missed a reference edge");
  pri_steady_a: assert property (
    (!tick && $stable(sel.small_drive) && $stable(sel.double_density))
      |=> $stable(primary_ctrl_clock_o) && $stable(write_clock_o))
    else $error("clock changed without a reference edge");
endmodule
`default_nettype wire

// >>> retrig_oneshot.sv
// Retriggerable one-shot timer
`default_nettype none
module retrig_oneshot #(
  parameter int DUR_W = fdsep_pkg::ONESHOT_W
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic             trigger_i,
  input  wire logic [DUR_W-1:0] duration_i,
  output logic                  fire_o
);
  logic             trig_q;  // Previous trigger level
  logic             edge_s;  // Either edge of the trigger
  logic [DUR_W-1:0] cnt_q;   // Cycles left

  // Trigger history
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_q <= 1'b1;
    end else begin
      trig_q <= trigger_i;
    end
  end
  assign edge_s = trigger_i ^ trig_q;

  // restart on every edge, else count down
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q  <= '0;
      fire_o <= 1'b0;
    end else if (edge_s) begin
      cnt_q  <= duration_i;
      fire_o <= (duration_i != '0);
    end else if (cnt_q > 1) begin
      cnt_q  <= cnt_q - 1'b1;
    end else begin
      cnt_q  <= '0;
      fire_o <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  oneshot_fire_a: assert property (
    (edge_s && duration_i > 3) |=> fire_o [*3])
    else $error("one-shot output not held after trigger");
endmodule
`default_nettype wire

// >>> floppy_read_data_separator.sv
// Floppy read data separator: clocks, data window, loop taps, timer
`default_nettype none
// How it works
// - Primary clock 8 or 4 MHz by size
// - Secondary clock 2 or 1 MHz by size
// - Write clock period 1, 2 or 4 us
// - Density select high MFM, low FM
// - Size select high small, low eight-inch
// - Sync field selects acquisition filter tap
// - ID and data fields select tracking tap
// - Controller gate marks gap and sync areas
// - Sample gate width equals write clock period
// - Regenerate drive pulses as read data
// - Gate timed to split data from clock
// - Retriggerable one-shot, externally set duration
// - Clock outputs taken from 16 MHz reference, window and timers from system clock
// - Raw whole-track read not supported
// - Zero-filled eight-inch gaps not supported
module floppy_read_data_separator #(
  parameter int DUR_W = fdsep_pkg::ONESHOT_W
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic             reference_osc_in_i,
  input  wire logic             drive_size_select_i,
  input  wire logic             density_select_i,
  input  wire logic             sync_gate_i,
  input  wire logic             raw_read_i,
  input  wire logic             oneshot_trigger_i,
  input  wire logic [DUR_W-1:0] timing_rc_node_i,
  output logic                  primary_ctrl_clock_o,
  output logic                  secondary_ctrl_clock_o,
  output logic                  write_clock_o,
  output logic                  read_data_o,
  output logic                  sample_gate_o,
  output logic                  acquire_filter_tap_o,
  output logic                  track_filter_tap_o,
  output logic                  oneshot_output_o
);
  // Counter widths from the package
  localparam int CW = fdsep_pkg::CELL_W;
  localparam int RW = fdsep_pkg::RD_W;

  // Window, read pulse and loop state
  mode_if                  sel ();   // Size and density to the divider
  logic [CW-1:0]           cell_len; // Gate half period in cycles
  logic [CW-1:0]           half_len; // Centre of a gate half
  logic                    rd_q;     // Previous raw read level
  logic                    rd_edge;  // Raw read rising edge
  logic [RW-1:0]           rd_cnt_q; // Read pulse cycles left
  logic [CW-1:0]           pos_q;    // Position inside gate half
  logic [CW-1:0]           pos_d;
  logic                    flip;     // Gate half ends
  logic signed [CW:0]      err;      // Pulse offset from centre
  logic signed [CW:0]      corr;     // Phase correction applied
  logic signed [CW:0]      nxt;      // Corrected next position
  fdsep_pkg::loop_mode_t   loop_q;   // Loop filter mode

  // selects passed straight to the divider
  assign sel.small_drive    = drive_size_select_i;
  assign sel.double_density = density_select_i;

  ref_clock_divider u_div (
    .mclk_i                 (mclk_i),
    .nrst_i                 (nrst_i),
    .reference_osc_in_i     (reference_osc_in_i),
    .sel                    (sel),
    .primary_ctrl_clock_o   (primary_ctrl_clock_o),
    .secondary_ctrl_clock_o (secondary_ctrl_clock_o),
    .write_clock_o          (write_clock_o)
  );

  retrig_oneshot #(
    .DUR_W (DUR_W)
  ) u_timer (
    .mclk_i     (mclk_i),
    .nrst_i     (nrst_i),
    .trigger_i  (oneshot_trigger_i),
    .duration_i (timing_rc_node_i),
    .fire_o     (oneshot_output_o)
  );

  // gate half length follows size and density
  always_comb begin
    unique case ({drive_size_select_i, density_select_i})
      // Eight-inch MFM, 1 us
      2'b01:   cell_len = fdsep_pkg::CELL_BASE_CYC;
      // Small FM, 4 us
      2'b10:   cell_len = fdsep_pkg::CELL_BASE_CYC << 2;
      // Eight-inch FM and small MFM, 2 us
      default: cell_len = fdsep_pkg::CELL_BASE_CYC << 1;
    endcase
  end
  // Window centre, half the window length
  assign half_len = cell_len >> 1;

  // Raw read history
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Line taken as low at reset
      rd_q <= 1'b0;
    end else begin
      rd_q <= raw_read_i;
    end
  end
  // every rising edge is taken, gap content is not checked
  assign rd_edge = raw_read_i & ~rd_q;

  // regenerate each read pulse at a fixed width
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Nothing running, line low
      rd_cnt_q    <= '0;
      read_data_o <= 1'b0;
    end else if (rd_edge) begin
      // Retrigger extends a pulse still running
      rd_cnt_q    <= fdsep_pkg::RD_PULSE_CYC;
      read_data_o <= 1'b1;
    end else if (rd_cnt_q > 1) begin
      // Pulse running, one cycle less
      rd_cnt_q    <= rd_cnt_q - 1'b1;
    end else begin
      // Count spent, line back low
      rd_cnt_q    <= '0;
      read_data_o <= 1'b0;
    end
  end

  // loop mode follows the controller gate
  // no raw track mode is offered
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Start in acquisition, as after a gap
      loop_q <= fdsep_pkg::LOOP_ACQUIRE;
    end else begin
      unique case (loop_q)
        // Stay in acquisition while the gap or sync area lasts
        fdsep_pkg::LOOP_ACQUIRE: begin
          if (!sync_gate_i) begin
            // Gate fell, fields follow, go track
            loop_q <= fdsep_pkg::LOOP_TRACK;
          end
        end
        // Return to acquisition at the next sync area
        fdsep_pkg::LOOP_TRACK: begin
          if (sync_gate_i) begin
            // New sync area, lock again
            loop_q <= fdsep_pkg::LOOP_ACQUIRE;
          end
        end
        // Illegal codes recover to acquisition
        default: loop_q <= fdsep_pkg::LOOP_ACQUIRE;
      endcase
    end
  end

  // one tap at a time
  // Acquisition while locking on a sync field
  assign acquire_filter_tap_o = (loop_q == fdsep_pkg::LOOP_ACQUIRE);
  // Tracking once the fields are read
  assign track_filter_tap_o   = (loop_q == fdsep_pkg::LOOP_TRACK);

  // phase error of a pulse against the gate half centre
  // Error is signed, one bit wider than the position
  assign err  = $signed({1'b0, pos_q}) - $signed({1'b0, half_len});
  // Full correction to lock, quarter correction to track
  // A process keeps the quarter step an arithmetic shift of a signed error
  always_comb begin
    // No pulse, no correction
    corr = '0;
    if (rd_edge) begin
      if (loop_q == fdsep_pkg::LOOP_ACQUIRE) begin
        // Acquisition takes the whole error at once
        corr = err;
      end else begin
        // Tracking takes a quarter, sign kept
        corr = err >>> 2;
      end
    end
  end
  // Step by one each cycle, less the correction
  assign nxt  = $signed({1'b0, pos_q}) - corr + $signed({{CW{1'b0}}, 1'b1});
  // Half ends when the count reaches the length, also after a mode change
  assign flip = (nxt >= $signed({1'b0, cell_len}));
  // Wrap to zero when the half ends
  assign pos_d = flip ? '0 : nxt[CW-1:0];

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Window starts low at position zero
      pos_q         <= '0;
      sample_gate_o <= 1'b0;
    end else begin
      // Step the position every cycle
      pos_q <= pos_d;
      if (flip) begin
        // Half over, window changes level
        sample_gate_o <= ~sample_gate_o;
      end
    end
  end

  // Checks
  // All checks on the system clock, off during reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  read_pulse_a: assert property (
    rd_edge |=> read_data_o [*8])
    else $error("read data pulse too short");

  read_end_a: assert property (
    (read_data_o && rd_cnt_q == 1 && !rd_edge) |=> !read_data_o)
    else $error("read data pulse did not end");

  // acquisition tap in the sync area
  acquire_tap_a: assert property (
    sync_gate_i |=> acquire_filter_tap_o && !track_filter_tap_o)
    else $error("acquisition tap not selected in sync area");

  track_tap_a: assert property (
    !sync_gate_i |=> track_filter_tap_o && !acquire_filter_tap_o)
    else $error("tracking tap not selected in fields");

  // gate flips at the end of each half
  gate_flip_a: assert property (
    (pos_q == cell_len - 1'b1 && !rd_edge) |=> $changed(sample_gate_o))
    else $error("sample gate did not flip at half end");

  gate_hold_a: assert property (
    (pos_q < cell_len - 1'b1 && !rd_edge && $stable(cell_len))
      |=> $stable(sample_gate_o) && pos_q == $past(pos_q) + 1'b1)
    else $error("sample gate moved inside a half");

  // acquisition centres the gate on the pulse
  gate_centre_a: assert property (
    (acquire_filter_tap_o && rd_edge && $stable(cell_len))
      |=> pos_q == $past(half_len) + 1'b1)
    else $error("gate not centred on pulse in acquisition");

  pos_range_a: assert property (
    $stable(cell_len) && $past(pos_q < cell_len) |-> pos_q < cell_len)
    else $error("gate position out of range");

  // Further checks of the window, read pulse, loop mode and timer

  // each raw edge rearms the full pulse
  read_rearm_a: assert property (
    rd_edge |=> read_data_o && rd_cnt_q == fdsep_pkg::RD_PULSE_CYC)
    else $error("read pulse not rearmed");

  // no pulse without a raw edge
  read_idle_a: assert property (
    (!read_data_o && !rd_edge) |=> !read_data_o)
    else $error("read data rose without a raw edge");

  // tracking pulls a late pulse part way
  track_late_a: assert property (
    (track_filter_tap_o && rd_edge && $stable(cell_len) && pos_q > half_len)
      |=> pos_q > $past(half_len) && pos_q <= $past(pos_q) + 1'b1)
    else $error("late pulse not pulled toward centre");

  // tracking pulls an early pulse part way
  track_early_a: assert property (
    (track_filter_tap_o && rd_edge && $stable(cell_len) && pos_q < half_len)
      |=> pos_q > $past(pos_q) && pos_q <= $past(half_len) + 1'b1)
    else $error("early pulse not pulled toward centre");

  // loop mode always a legal code
  loop_legal_a: assert property (
    $onehot(loop_q))
    else $error("loop mode code illegal");

  // every window change starts a new half
  gate_start_a: assert property (
    $changed(sample_gate_o) |-> pos_q == '0)
    else $error("window changed away from a half start");

  // timer stays off without a trigger edge
  timer_quiet_a: assert property (
    ($past(nrst_i) && $stable(oneshot_trigger_i) && !oneshot_output_o)
      |=> !oneshot_output_o)
    else $error("timer fired without a trigger edge");

  // Coverage of the main scenarios
  acq_lock_c: cover property (
    acquire_filter_tap_o && rd_edge ##1 !sync_gate_i ##1 track_filter_tap_o);
  track_pulse_c: cover property (track_filter_tap_o && rd_edge);
  small_fm_c: cover property (
    drive_size_select_i && !density_select_i && flip);
  timer_c: cover property ($fell(oneshot_output_o));
  // Tracking correction of an early pulse
  early_pulse_c: cover property (track_filter_tap_o && rd_edge && pos_q < half_len);
endmodule
`default_nettype wire

// >>> fdsep_far_end.sv
// Far-side model: 16 MHz reference oscillator and drive read pulses
`default_nettype none
module fdsep_far_end (
  input  wire logic mclk_i,
  output logic      ref_osc_o,
  output logic      raw_read_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ref_osc_o = 1'b0;
    // Offset keeps reference edges off the system clock edges
    #2;
    forever #31.25 ref_osc_o = ~ref_osc_o;
  end
  // Idle drive line rests low between pulses
  initial raw_read_o = 1'b0;
  // One pulse after a gap of gap_cyc cycles, high for hi_cyc cycles
  task automatic read_pulse(input int gap_cyc, input int hi_cyc);
    repeat (gap_cyc) @(posedge mclk_i);
    #1 raw_read_o = 1'b1;
    repeat (hi_cyc) @(posedge mclk_i);
    #1 raw_read_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb_floppy_read_data_separator.sv
// Self-checking bench of the floppy read data separator
`default_nettype none
module tb_floppy_read_data_separator;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, nrst_i;           // Clock and reset
  logic        ref_osc, raw_read;        // Far-side lines
  logic        size_sel, dens_sel;       // Mode selects
  logic        sync_gate, trig;          // Controller gate, timer trigger
  logic [15:0] dur;                      // Timer duration
  logic        pri_clk, sec_clk, wr_clk; // Clock outputs
  logic        rd_data, gate, acq, trk;  // Data path outputs
  logic        os_out;                   // Timer output
  int          fail_count = 0;           // Mismatches
  int          comparisons = 0;          // Compares made
  int          rd_q[$], os_q[$];         // Expected pulse widths
  int          rd_len = 0, os_len = 0;   // Running pulse widths
  int          len;                      // Measured window

  floppy_read_data_separator dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .reference_osc_in_i(ref_osc),
    .drive_size_select_i(size_sel), .density_select_i(dens_sel),
    .sync_gate_i(sync_gate), .raw_read_i(raw_read), .oneshot_trigger_i(trig),
    .timing_rc_node_i(dur), .primary_ctrl_clock_o(pri_clk),
    .secondary_ctrl_clock_o(sec_clk), .write_clock_o(wr_clk), .read_data_o(rd_data),
    .sample_gate_o(gate), .acquire_filter_tap_o(acq), .track_filter_tap_o(trk),
    .oneshot_output_o(os_out));
  fdsep_far_end far (.mclk_i(mclk_i), .ref_osc_o(ref_osc), .raw_read_o(raw_read));

  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Count compare with a tolerance
  task automatic chk(input int got, input int exp, input int tol, input string what);
    comparisons++;
    if (got > exp + tol || got < exp - tol) begin
      fail_count++;
      $display("ERROR %0t %s: got %0d, expected %0d", $time, what, got, exp);
    end
  endtask
  // Single-bit compare, unknown never matches
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %b, expected %b", $time, what, got, exp);
    end
  endtask
  // Finished pulse against the oldest note; a pulse with no note fails
  task automatic take(input logic v, ref int n, ref int q[$], input string what);
    if (v === 1'b1) begin
      n++;
    end else if (n > 0) begin
      if (q.size() == 0) chk(n, 0, 0, what);
      else chk(n, q.pop_front(), 0, what);
      n = 0;
    end
  endtask
  // Output watcher
  always @(posedge mclk_i) begin
    take(rd_data, rd_len, rd_q, "read width");
    take(os_out, os_len, os_q, "timer width");
  end
  // Rising edges of the three clocks over 16 us
  task automatic rates(input logic s, input logic d);
    logic [2:0] now, prev;
    int n [3];
    prev = 3'b111;
    n = '{0, 0, 0};
    repeat (1600) begin
      @(posedge mclk_i);
      now = {wr_clk, sec_clk, pri_clk};
      for (int k = 0; k < 3; k++) if (now[k] === 1'b1 && prev[k] === 1'b0) n[k]++;
      prev = now;
    end
    chk(n[0], 128 >> int'(s), 1, "primary rate");
    chk(n[1], 32 >> int'(s), 1, "secondary rate");
    chk(n[2], 16 >> (int'(s) + int'(!d)), 1, "write rate");
  endtask
  // Cycles between two window toggles, bounded
  task automatic gate_len(output int n);
    logic g;
    int t;
    g = gate;
    t = 0;
    while (gate === g && t < 1000) begin @(posedge mclk_i); t++; end
    g = gate;
    n = 0;
    while (gate === g && n < 1000) begin @(posedge mclk_i); n++; end
  endtask
  // Verdict, reached from the main sequence or the watchdog
  task automatic end_of_test();
    if (rd_q.size() + os_q.size() != 0) begin
      fail_count++;
      $display("ERROR %0t expected pulses never seen", $time);
    end
    $display("Counts: %0d compares, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'he7628e1b));
    nrst_i = 1'b0;
    {size_sel, dens_sel, sync_gate, trig} = 4'h5;
    dur = 16'h0000;
    repeat (20) @(posedge mclk_i);
    chk_bit(acq, 1'b1, "reset acquire tap");
    chk_bit(pri_clk | sec_clk | wr_clk | rd_data, 1'b0, "reset outputs");
    chk_bit(gate | trk | os_out, 1'b0, "reset window");
    #1 nrst_i = 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk_i);
      #1 {size_sel, dens_sel} = 2'(m);
      repeat (500) @(posedge mclk_i);
      rates(size_sel, dens_sel);
      gate_len(len);
      chk(len, int'(fdsep_pkg::CELL_BASE_CYC) << (int'(size_sel) + int'(!dens_sel)), 0,
          "window");
    end
    // taps follow the gate one cycle later
    @(posedge mclk_i);
    #1 sync_gate = 1'b1;
    chk_bit(acq, 1'b0, "acquire early");
    @(posedge mclk_i);
    #1 chk_bit(acq, 1'b1, "acquire");
    chk_bit(trk, 1'b0, "track off");
    sync_gate = 1'b0;
    @(posedge mclk_i);
    #1 chk_bit(trk, 1'b1, "track");
    chk_bit(acq, 1'b0, "acquire off");
    // drive pulses return at fixed width, slow and prompt gaps
    for (int i = 0; i < 6; i++) begin
      sync_gate = 1'(i);
      rd_q.push_back(int'(fdsep_pkg::RD_PULSE_CYC));
      far.read_pulse(2 + $urandom % 40, 15);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_i);
      #1 dur = 16'(1 + $urandom % 8);
      os_q.push_back(int'(dur));
      trig = ~trig;
      repeat (12) @(posedge mclk_i);
    end
    // restart three cycles in, then a zero duration
    #1 dur = 16'h0006;
    os_q.push_back(3 + 6);
    trig = ~trig;
    repeat (3) @(posedge mclk_i);
    #1 trig = ~trig;
    repeat (12) @(posedge mclk_i);
    #1 dur = 16'h0000;
    trig = ~trig;
    repeat (20) @(posedge mclk_i);
    end_of_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge mclk_i);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
